//--- hw/sbp_pkg.sv
// Shared constants for the suspend, resume and busy-poll decoder
package sbp_pkg;

  // Serial opcodes
  localparam logic [7:0] OP_ERASE_SUSPEND = 8'h75;
  localparam logic [7:0] OP_ERASE_RESUME = 8'h7A;
  localparam logic [7:0] OP_PROG_SUSPEND = 8'h85;
  localparam logic [7:0] OP_PROG_RESUME = 8'h8A;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;

  // Status byte layout
  localparam int ST_BUSY_BIT = 0;

  // Parameter word with the four suspend and resume opcodes
  localparam logic [31:0] PARAM_SUSP_WORD = {OP_ERASE_SUSPEND, OP_ERASE_RESUME,
                                             OP_PROG_SUSPEND, OP_PROG_RESUME};

  // Power-down and polling parameter word fields
  localparam logic PD_ABSENT = 1'b1;
  localparam logic [7:0] PD_ENTER_OP = 8'hFF;
  localparam logic [7:0] PD_EXIT_OP = 8'hFF;
  localparam logic [1:0] PD_EXIT_UNITS = 2'b11;
  localparam logic [4:0] PD_EXIT_COUNT = 5'b11111;
  localparam logic [3:0] PD_RSVD_HI = 4'hF;
  localparam logic [1:0] POLL_MODE = 2'b01;
  localparam logic [1:0] PD_RSVD_LO = 2'b11;

  // APB register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_PARAM_SUSP = 12'h008;
  localparam logic [11:0] REG_PARAM_PD = 12'h00C;

  // Control register bits (write one to pulse)
  localparam int CTRL_START_ERASE = 0;
  localparam int CTRL_START_PROG = 1;
  localparam int CTRL_FINISH = 2;

  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_STATE_LSB = 1;
  localparam int STAT_OP_LSB = 8;
  localparam int STAT_IGN_LSB = 16;

  typedef enum logic [2:0] {
    SBP_IDLE = 3'b000,
    SBP_ERASE = 3'b001,
    SBP_ERASE_HOLD = 3'b010,
    SBP_PROG = 3'b011,
    SBP_PROG_HOLD = 3'b100
  } sbp_state_t;

endpackage

//--- hw/sbp_spi_if.sv
// Serial byte receiver and transmitter, SPI mode 0, oversampled by mclk
`timescale 1ns/1ps
`default_nettype none
module sbp_spi_if (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic tx_en_i,
  input wire logic [7:0] tx_byte_i,
  output logic sel_o,
  output logic [7:0] rx_byte_o,
  output logic rx_vld_o,
  output logic rx_first_o,
  output logic miso_o,
  output logic miso_oe_o
);

  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic cs_s1;
    logic cs_s2;
    logic mosi_s1;
    logic mosi_s2;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic first;
    logic [7:0] rx_byte;
    logic rx_vld;
    logic rx_first;
    logic miso;
    logic miso_oe;
  } sbp_spi_st_t;

  sbp_spi_st_t st_r;
  sbp_spi_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // Pins cross into mclk through two flops; sck gets a third flop so its second and third form the edge detect
    st_nxt.sck_s1 = sck_i;
    st_nxt.sck_s2 = st_r.sck_s1;
    st_nxt.sck_s3 = st_r.sck_s2;
    st_nxt.cs_s1 = cs_n_i;
    st_nxt.cs_s2 = st_r.cs_s1;
    st_nxt.mosi_s1 = mosi_i;
    st_nxt.mosi_s2 = st_r.mosi_s1;
    st_nxt.rx_vld = 1'b0;
    st_nxt.miso_oe = ~st_r.cs_s2 & tx_en_i;
    if (st_r.cs_s2) begin
      st_nxt.bit_cnt = 3'd0;
      st_nxt.first = 1'b1;
      st_nxt.miso = 1'b0;
    end else if (st_r.sck_s2 && !st_r.sck_s3) begin
      st_nxt.rx_sh = {st_r.rx_sh[6:0], st_r.mosi_s2};
      st_nxt.bit_cnt = st_r.bit_cnt + 3'd1;
      if (st_r.bit_cnt == 3'd7) begin
        st_nxt.rx_byte = {st_r.rx_sh[6:0], st_r.mosi_s2};
        st_nxt.rx_vld = 1'b1;
        st_nxt.rx_first = st_r.first;
        st_nxt.first = 1'b0;
      end
    end else if (!st_r.sck_s2 && st_r.sck_s3) begin
      // Load at a byte boundary so the first bit is out before the next rise
      if (st_r.bit_cnt == 3'd0) begin
        st_nxt.tx_sh = tx_byte_i;
        st_nxt.miso = tx_byte_i[7];
      end else begin
        st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
        st_nxt.miso = st_r.tx_sh[6];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.sck_s1 <= 1'b0;
      st_r.cs_s1 <= 1'b1;
      st_r.cs_s2 <= 1'b1;
      st_r.first <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sel_o = ~st_r.cs_s2;
  assign rx_byte_o = st_r.rx_byte;
  assign rx_vld_o = st_r.rx_vld;
  assign rx_first_o = st_r.rx_first;
  assign miso_o = st_r.miso;
  assign miso_oe_o = st_r.miso_oe;

endmodule // sbp_spi_if
`default_nettype wire

//--- hw/sbp_top.sv
// Suspend, resume and busy-poll opcode decoder with APB registers
`timescale 1ns/1ps
`default_nettype none
module sbp_top (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic engine_done_i,
  output logic erase_run_o,
  output logic erase_hold_o,
  output logic prog_run_o,
  output logic prog_hold_o
);

  typedef struct packed {
    sbp_pkg::sbp_state_t state;
    logic in_status;
    logic [7:0] last_op;
    logic [7:0] ign_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sbp_top_st_t;

  sbp_top_st_t st_r;
  sbp_top_st_t st_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic sel;
  logic [7:0] rx_byte;
  logic rx_vld;
  logic rx_first;
  logic busy;
  logic [7:0] status_byte;
  logic [31:0] param_pd;
  logic [31:0] status_word;
  logic wr_ctrl;
  logic ign;

  // Reset is released through two flops so every state flop leaves reset together
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  sbp_spi_if u_spi (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .mosi_i(mosi_i),
    .tx_en_i(st_r.in_status),
    .tx_byte_i(status_byte),
    .sel_o(sel),
    .rx_byte_o(rx_byte),
    .rx_vld_o(rx_vld),
    .rx_first_o(rx_first),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o)
  );

  assign busy = (st_r.state == sbp_pkg::SBP_ERASE) || (st_r.state == sbp_pkg::SBP_PROG);
  assign status_byte = {7'd0, busy};

  assign param_pd = {sbp_pkg::PD_ABSENT, sbp_pkg::PD_ENTER_OP, sbp_pkg::PD_EXIT_OP,
                     sbp_pkg::PD_EXIT_UNITS, sbp_pkg::PD_EXIT_COUNT, sbp_pkg::PD_RSVD_HI,
                     sbp_pkg::POLL_MODE, sbp_pkg::PD_RSVD_LO};

  assign status_word = {8'd0, st_r.ign_cnt, st_r.last_op, 4'd0, st_r.state, busy};

  assign wr_ctrl = psel_i && penable_i && st_r.pready && pwrite_i &&
                   (paddr_i == sbp_pkg::REG_CTRL);

  always_comb begin
    st_nxt = st_r;
    ign = 1'b0;
    // APB: decode in setup, answer in the first access cycle
    st_nxt.pready = psel_i && !penable_i;
    st_nxt.pslverr = 1'b0;
    if (psel_i && !penable_i) begin
      st_nxt.prdata = 32'h0000_0000;
      case (paddr_i)
        sbp_pkg::REG_CTRL: st_nxt.prdata = 32'h0000_0000;
        sbp_pkg::REG_STATUS: st_nxt.prdata = status_word;
        sbp_pkg::REG_PARAM_SUSP: st_nxt.prdata = sbp_pkg::PARAM_SUSP_WORD;
        sbp_pkg::REG_PARAM_PD: st_nxt.prdata = param_pd;
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
    // Status read lasts for the rest of the frame
    if (!sel) begin
      st_nxt.in_status = 1'b0;
    end
    // Engine lifecycle driven by software starts and engine completion
    if (wr_ctrl && (st_r.state == sbp_pkg::SBP_IDLE)) begin
      if (pwdata_i[sbp_pkg::CTRL_START_ERASE]) begin
        st_nxt.state = sbp_pkg::SBP_ERASE;
      end else if (pwdata_i[sbp_pkg::CTRL_START_PROG]) begin
        st_nxt.state = sbp_pkg::SBP_PROG;
      end
    end
    if ((engine_done_i || (wr_ctrl && pwdata_i[sbp_pkg::CTRL_FINISH])) && busy) begin
      st_nxt.state = sbp_pkg::SBP_IDLE;
    end
    // Opcodes are the first byte of a frame; serial wins over engine in one cycle
    if (rx_vld && rx_first) begin
      st_nxt.last_op = rx_byte;
      case (rx_byte)
        sbp_pkg::OP_ERASE_SUSPEND: begin
          if (st_r.state == sbp_pkg::SBP_ERASE) begin
            st_nxt.state = sbp_pkg::SBP_ERASE_HOLD;
          end else begin
            ign = 1'b1;
          end
        end
        sbp_pkg::OP_ERASE_RESUME: begin
          if (st_r.state == sbp_pkg::SBP_ERASE_HOLD) begin
            st_nxt.state = sbp_pkg::SBP_ERASE;
          end else begin
            ign = 1'b1;
          end
        end
        sbp_pkg::OP_PROG_SUSPEND: begin
          if (st_r.state == sbp_pkg::SBP_PROG) begin
            st_nxt.state = sbp_pkg::SBP_PROG_HOLD;
          end else begin
            ign = 1'b1;
          end
        end
        sbp_pkg::OP_PROG_RESUME: begin
          if (st_r.state == sbp_pkg::SBP_PROG_HOLD) begin
            st_nxt.state = sbp_pkg::SBP_PROG;
          end else begin
            ign = 1'b1;
          end
        end
        sbp_pkg::OP_READ_STATUS: st_nxt.in_status = 1'b1;
        default: ;
      endcase
    end
    // Saturates so software can tell an out-of-state suspend or resume opcode happened; unknown opcodes are not counted
    if (ign && (st_r.ign_cnt != 8'hFF)) begin
      st_nxt.ign_cnt = st_r.ign_cnt + 8'd1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.state <= sbp_pkg::SBP_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata_o = st_r.prdata;
  assign pready_o = st_r.pready;
  assign pslverr_o = st_r.pslverr && st_r.pready;
  assign erase_run_o = (st_r.state == sbp_pkg::SBP_ERASE);
  assign erase_hold_o = (st_r.state == sbp_pkg::SBP_ERASE_HOLD);
  assign prog_run_o = (st_r.state == sbp_pkg::SBP_PROG);
  assign prog_hold_o = (st_r.state == sbp_pkg::SBP_PROG_HOLD);

endmodule // sbp_top
`default_nettype wire

//--- tb/sbp_top_sva.sv
// Port assertions for the suspend, resume and busy-poll decoder
`timescale 1ns/1ps
`default_nettype none
module sbp_top_chk (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic erase_run_o,
  input wire logic erase_hold_o,
  input wire logic prog_run_o,
  input wire logic prog_hold_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_rd(a);
    psel_i && pready_o && !pwrite_i && paddr_i == a;
  endsequence
  chk_pready_next: assert property (s_setup |=> pready_o)
    else $error("no ready after setup");
  chk_pd_word: assert property (
    s_rd(12'h00C) |-> prdata_o == 32'hFFFF_FFF7) else $error("power-down word wrong");
  chk_susp_word: assert property (
    s_rd(12'h008) |-> prdata_o == 32'h757A_858A) else $error("suspend word wrong");
  chk_busy_bit: assert property (
    s_rd(12'h004) |-> prdata_o[0] == $past(erase_run_o || prog_run_o))
    else $error("status busy bit wrong");
  chk_unmapped_err: assert property (
    psel_i && pready_o && paddr_i > 12'h00C |-> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_erase_susp: assert property ($rose(erase_hold_o) |-> $fell(erase_run_o))
    else $error("erase hold without running erase");
  chk_erase_res: assert property ($fell(erase_hold_o) |-> erase_run_o)
    else $error("erase hold left without resume");
  chk_prog_susp: assert property ($rose(prog_hold_o) |-> $fell(prog_run_o))
    else $error("program hold without running program");
  chk_prog_res: assert property ($fell(prog_hold_o) |-> prog_run_o)
    else $error("program hold left without resume");
  chk_state_excl: assert property (
    $onehot0({erase_run_o, erase_hold_o, prog_run_o, prog_hold_o}))
    else $error("more than one state output high");
endmodule // sbp_top_chk
bind sbp_top sbp_top_chk u_sbp_top_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .erase_run_o(erase_run_o),
  .erase_hold_o(erase_hold_o), .prog_run_o(prog_run_o), .prog_hold_o(prog_hold_o));
`default_nettype wire

//--- tb/sbp_host_model.sv
// SPI host model sending opcode frames in mode 0
`timescale 1ns/1ps
`default_nettype none
module sbp_host_model (
  input wire logic mclk_i,
  input wire logic miso_i,
  input wire logic miso_oe_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Half periods of 5 clocks or more keep sck under 12.5 MHz
  task automatic frame(input logic [7:0] op, input int nb, output logic [7:0] rx,
                       output logic oe);
    logic [7:0] tx;
    tx = op;
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    for (int b = 0; b < nb; b++) begin
      for (int i = 7; i >= 0; i--) begin
        repeat (5) @(posedge mclk_i);
        mosi_o <= tx[i];
        repeat (5) @(posedge mclk_i);
        sck_o <= 1'b1;
        rx = {rx[6:0], miso_i};
        repeat (5) @(posedge mclk_i);
        sck_o <= 1'b0;
      end
      tx = 8'h00;
      oe = miso_oe_i;
    end
    repeat (5) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    // Released line shows the inverse, not a stale bit
    mosi_o <= ~mosi_o;
    repeat (6) @(posedge mclk_i);
  endtask
endmodule // sbp_host_model
`default_nettype wire

//--- tb/sbp_top_bench.sv
// Bench for the suspend, resume and busy-poll decoder
`timescale 1ns/1ps
`default_nettype none
module sbp_top_bench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic done = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic pready, pslverr, sck, cs_n, mosi, miso, miso_oe, e, oe;
  logic [7:0] rx;
  wire [3:0] st;
  int n_mismatch = 0;
  int total_checks = 0;
  always #5 mclk = ~mclk;
  sbp_top u_sbp_top (.mclk_i(mclk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .engine_done_i(done), .erase_run_o(st[3]),
    .erase_hold_o(st[2]), .prog_run_o(st[1]), .prog_hold_o(st[0]));
  sbp_host_model u_sbp_host_model (.mclk_i(mclk), .miso_i(miso), .miso_oe_i(miso_oe),
    .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      chk(32'h0000_0000, 32'h0000_0001, "apb timeout");
      end_sim();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic op(input logic [7:0] c, input logic [3:0] exp);
    u_sbp_host_model.frame(c, 1, rx, oe);
    chk(32'(st), 32'(exp), "state after opcode");
  endtask
  task automatic busy(input logic b);
    u_sbp_host_model.frame(8'h05, 2, rx, oe);
    chk(32'(oe), 32'h0000_0001, "status not driven");
    chk(32'(rx[0]), 32'(b), "busy bit");
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(r, 32'hFFFF_FFF7, "power-down word");
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(r, 32'h757A_858A, "suspend word");
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001, "unmapped error");
    chk(r, 32'h0000_0000, "unmapped data");
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(32'(st), 32'h0000_0008, "erase start");
    busy(1'b1);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({28'h000_0000, r[3:0]}, 32'h0000_0003, "status while erasing");
    op(8'h7A, 4'h8);
    op(8'h75, 4'h4);
    busy(1'b0);
    op(8'h85, 4'h4);
    op(8'h7A, 4'h8);
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
    busy(1'b0);
    apb(1'b1, 12'h000, 32'h0000_0002);
    op(8'h85, 4'h1);
    op(8'h8A, 4'h2);
    apb(1'b1, 12'h000, 32'h0000_0004);
    op(8'h8A, 4'h0);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({24'h00_0000, r[23:16]}, 32'h0000_0003, "ignored count");
    chk({16'h0000, r[15:0]}, 32'h0000_8A00, "last opcode and idle");
    end_sim();
  end
endmodule // sbp_top_bench
`default_nettype wire
